/* core/slbc_cfg.svh */
// Constants for the strap latch boot configuration block: offsets, fields, reset values.
// Assumes inclusion by bare name from files under core/.
`ifndef SLBC_CFG_SVH
`define SLBC_CFG_SVH
// Register byte offsets
`define SLBC_STRAP_OFS      12'h000
`define SLBC_CTRL_OFS       12'h004
`define SLBC_STATUS_OFS     12'h008
// Strap status fields
`define SLBC_BIT_SUPPLY     0
`define SLBC_BIT_BOOT       1
`define SLBC_BIT_DLQ        2
`define SLBC_BIT_LOG        3
`define SLBC_BIT_SDIO       4
`define SLBC_NSTRAP         5
// Control fields
`define SLBC_CTRL_VOLT_OVR  0
`define SLBC_CTRL_VOLT_VAL  1
`define SLBC_CTRL_TIME_OVR  2
`define SLBC_CTRL_TIME_IN   3
`define SLBC_CTRL_TIME_OUT  4
`define SLBC_CTRL_RST       5'h00
// Pull direction per strap, 1 = pull-up
`define SLBC_PULL_UP_MASK   5'h1a
`endif

/* core/slbc_pkg.sv */
// Types for the strap latch boot configuration block.
// Assumes the constants header is compiled alongside.
package slbc_pkg;
  // Boot source decoded from straps
  typedef enum logic [1:0] {
    SLBC_BOOT_FLASH    = 2'b00,
    SLBC_BOOT_DOWNLOAD = 2'b01,
    SLBC_BOOT_UNDEF    = 2'b10
  } slbc_boot_t;
endpackage : slbc_pkg

/* core/slbc_strap_cell.sv */
// One strap latch cell: pull control, capture at reset release, hold.
// Assumes pad input is synchronous to pclk and at least one pclk edge falls inside reset.
`timescale 1ns/10ps
module slbc_strap_cell #(
  parameter bit PULL_UP = 1'b0          // Pull direction during reset
) (
  input  wire logic pclk,               // System clock
  input  wire logic presetn,            // Async reset, active low
  input  wire logic pad_in,             // Pad level
  output logic      pull_up_en,         // Weak pull-up request
  output logic      pull_dn_en,         // Weak pull-down request
  output logic      strap_q             // Captured bit
);
  logic strap_r;                        // Latched value, no reset: it must load while reset holds

  // Follow the pad on every edge under reset; the last edge before release closes it.
  // Sampling after release would see the pad with the weak pulls already gone.
  always_ff @(posedge pclk) begin
    if (!presetn) begin
      strap_r <= pad_in;
    end
  end

  // Transparent while reset holds, closed afterwards
  assign strap_q    = presetn ? strap_r : pad_in;
  assign pull_up_en = !presetn &&  PULL_UP;
  assign pull_dn_en = !presetn && !PULL_UP;
endmodule : slbc_strap_cell

/* core/slbc_apb_regs.sv */
// APB slave for the strap block: strap status, control overrides, decode status.
// Assumes a standard APB master; zero wait states.
`timescale 1ns/10ps
`include "slbc_cfg.svh"
module slbc_apb_regs (
  input  wire logic        pclk,        // System clock
  input  wire logic        presetn,     // Async reset, active low
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB access phase
  input  wire logic        pwrite,      // APB direction
  input  wire logic [11:0] paddr,       // APB byte address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic [31:0]      prdata,      // APB read data
  output logic             pready,      // APB ready
  output logic             pslverr,     // APB error
  input  wire logic [4:0]  strap_bits,  // Captured straps
  input  wire logic [3:0]  status_bits, // Decoded settings
  output logic [4:0]       ctrl_r       // Override controls
);
  logic acc;                            // Access phase strobe
  logic hit;                            // Mapped address

  assign acc     = psel && penable;
  assign hit     = (paddr == `SLBC_STRAP_OFS) || (paddr == `SLBC_CTRL_OFS)
                   || (paddr == `SLBC_STATUS_OFS);
  assign pready  = 1'b1;                // No wait states
  assign pslverr = acc && !hit;         // Unmapped answers with error

  // Control writes; only this register is writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `SLBC_CTRL_RST;
    end else if (acc && pwrite && paddr == `SLBC_CTRL_OFS) begin
      ctrl_r <= pwdata[4:0];
    end
  end

  // Registered read data, loaded in setup so it is valid in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `SLBC_STRAP_OFS) begin
        prdata <= {27'h0, strap_bits};
      end else if (paddr == `SLBC_CTRL_OFS) begin
        prdata <= {27'h0, ctrl_r};
      end else if (paddr == `SLBC_STATUS_OFS) begin
        prdata <= {28'h0, status_bits};
      end else begin
        prdata <= 32'h0000_0000;        // Unmapped reads zero
      end
    end
  end
endmodule : slbc_apb_regs

/* core/slbc_top.sv */
// Strap latch boot configuration: captures five straps during reset and decodes settings.
// Operation
// - Sample five straps during system reset
// - Hold straps until the next system reset, when they are sampled again
// - Straps readable in one status register
// - Weak pulls on straps during reset
// - Release pins to function after reset
// - Supply strap selects 3.3 or 1.8
// - Boot select picks flash or download
// - Log strap enables boot console output
// - Strap pair sets SDIO edge timing
// - Firmware may override voltage and timing
// Assumes presetn covers power-on, watchdog and brownout resets.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "slbc_cfg.svh"
module slbc_top (
  input  wire logic        pclk,                  // System clock, 25 MHz
  input  wire logic        presetn,               // Async system reset, active low
  input  wire logic        psel,                  // APB select
  input  wire logic        penable,               // APB enable
  input  wire logic        pwrite,                // APB write
  input  wire logic [11:0] paddr,                 // APB address
  input  wire logic [31:0] pwdata,                // APB write data
  output logic [31:0]      prdata,                // APB read data
  output logic             pready,                // APB ready
  output logic             pslverr,               // APB error
  input  wire logic        supply_select_strap,   // Pad levels, externally driven
  input  wire logic        boot_select_strap,     // Boot source pad
  input  wire logic        download_qualify_strap,// Download qualify pad
  input  wire logic        log_timing_strap,      // Log and timing pad
  input  wire logic        sdio_edge_strap,       // SDIO edge pad
  output logic [4:0]       strap_pull_up_en,      // Weak pull-up enables
  output logic [4:0]       strap_pull_dn_en,      // Weak pull-down enables
  output logic             strap_func_en,         // Pins in normal function
  output logic             flash_vdd_1v8,         // 1 = 1.8 V, 0 = 3.3 V
  output logic             boot_download,         // Download boot selected
  output logic             boot_undefined,        // Unsupported strap combination
  output logic             console_log_en,        // Boot console log enable
  output logic             sdio_in_rising,        // SDIO input sample edge
  output logic             sdio_out_rising        // SDIO output launch edge
);
  logic [4:0] pads;                               // Pad vector
  logic [4:0] strap;                              // Captured straps
  logic [4:0] ctrl_r;                             // Override controls
  logic [3:0] status;                             // Effective settings
  slbc_pkg::slbc_boot_t boot_r;                   // Decoded boot source
  logic vdd_r;                                    // Effective voltage select
  logic log_r;                                    // Log enable
  logic sin_r;                                    // SDIO input edge
  logic sout_r;                                   // SDIO output edge

  assign pads = {sdio_edge_strap, log_timing_strap, download_qualify_strap,
                 boot_select_strap, supply_select_strap};

  // One latch cell per strap
  genvar gi;
  generate
    for (gi = 0; gi < `SLBC_NSTRAP; gi++) begin : g_cell
      slbc_strap_cell #(
        .PULL_UP (bit'((`SLBC_PULL_UP_MASK >> gi) & 1))
      ) u_cell (
        .pclk       (pclk),
        .presetn    (presetn),
        .pad_in     (pads[gi]),
        .pull_up_en (strap_pull_up_en[gi]),
        .pull_dn_en (strap_pull_dn_en[gi]),
        .strap_q    (strap[gi])
      );
    end
  endgenerate

  // Pins return to function once reset releases
  assign strap_func_en = presetn;

  // Boot source decode; flash wins regardless of qualifier
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_r <= slbc_pkg::SLBC_BOOT_FLASH;
    end else if (strap[`SLBC_BIT_BOOT]) begin
      boot_r <= slbc_pkg::SLBC_BOOT_FLASH;
    end else if (!strap[`SLBC_BIT_DLQ]) begin
      boot_r <= slbc_pkg::SLBC_BOOT_DOWNLOAD;
    end else begin
      boot_r <= slbc_pkg::SLBC_BOOT_UNDEF;       // Combination not defined
    end
  end

  // Voltage select with firmware override
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vdd_r <= 1'b0;
    end else if (ctrl_r[`SLBC_CTRL_VOLT_OVR]) begin
      vdd_r <= ctrl_r[`SLBC_CTRL_VOLT_VAL];
    end else begin
      vdd_r <= strap[`SLBC_BIT_SUPPLY];
    end
  end

  // Console log enable follows log strap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_r <= 1'b1;
    end else begin
      log_r <= strap[`SLBC_BIT_LOG];
    end
  end

  // SDIO timing pair, overridable after boot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sin_r  <= 1'b1;
      sout_r <= 1'b1;
    end else if (ctrl_r[`SLBC_CTRL_TIME_OVR]) begin
      sin_r  <= ctrl_r[`SLBC_CTRL_TIME_IN];
      sout_r <= ctrl_r[`SLBC_CTRL_TIME_OUT];
    end else begin
      sin_r  <= strap[`SLBC_BIT_LOG];
      sout_r <= strap[`SLBC_BIT_SDIO];
    end
  end

  assign flash_vdd_1v8   = vdd_r;
  assign boot_download   = (boot_r == slbc_pkg::SLBC_BOOT_DOWNLOAD);
  assign boot_undefined  = (boot_r == slbc_pkg::SLBC_BOOT_UNDEF);
  assign console_log_en  = log_r;
  assign sdio_in_rising  = sin_r;
  assign sdio_out_rising = sout_r;
  assign status          = {sout_r, sin_r, log_r, vdd_r};

  // Register file over APB
  slbc_apb_regs u_regs (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .strap_bits  (strap),
    .status_bits (status),
    .ctrl_r      (ctrl_r)
  );
endmodule : slbc_top

/* tb/slbc_pad_model.sv */
// Pad model: external drivers, the weak pulls and floating pins of the straps.
// Assumes pull enables come from the device and drive enables come from the bench.
`timescale 1ns/10ps
module slbc_pad_model (
  input  logic       pclk,       // Clock for the floating pattern
  input  logic [4:0] drv_en,     // External driver active per pad
  input  logic [4:0] drv_val,    // External driver level
  input  logic [4:0] pull_up_en, // Device weak pull-ups
  input  logic [4:0] pull_dn_en, // Device weak pull-downs
  output logic [4:0] pad         // Resolved pad levels
);
  logic [4:0] float_r = 5'h00; // Toggles so a floating pin never looks settled
  // Floating pattern
  always_ff @(posedge pclk) float_r <= ~float_r;
  // External drive beats the weak pulls
  assign pad = (drv_en & drv_val) | (~drv_en & (pull_up_en | (~pull_dn_en & float_r)));
endmodule : slbc_pad_model

/* tb/slbc_checker.sv */
// Checker for the strap block: settled decode, strap readback, APB answers.
// Assumes binding to slbc_top and pads held stable around reset release.
`timescale 1ns/10ps
module slbc_checker (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        supply_select_strap,
  input logic        boot_select_strap,
  input logic        download_qualify_strap,
  input logic        log_timing_strap,
  input logic        sdio_edge_strap,
  input logic [4:0]  strap_pull_up_en,
  input logic [4:0]  strap_pull_dn_en,
  input logic        strap_func_en,
  input logic        boot_download,
  input logic        boot_undefined,
  input logic        console_log_en
);
  logic [1:0] set_r; // Edges since release, saturates at 3
  logic [4:0] cap_r; // Own copy of the captured straps
  logic       map_w; // Address is one of the three registers
  assign map_w = paddr inside {12'h000, 12'h004, 12'h008};
  // Follow the pads while reset holds; the last edge in reset is the closing one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) set_r <= 2'h0;
    else if (set_r != 2'h3) set_r <= set_r + 2'h1;
  end
  always_ff @(posedge pclk) begin
    if (!presetn) cap_r <= {sdio_edge_strap, log_timing_strap, download_qualify_strap,
                                            boot_select_strap, supply_select_strap};
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_settled; set_r == 2'h3; endsequence
  sequence s_rd_setup; psel && !penable && !pwrite; endsequence
  a_pull_off_run: assert property (strap_pull_up_en == 5'h00 && strap_pull_dn_en == 5'h00)
    else $error("pulls active after reset");
  a_func_on_run: assert property (strap_func_en) else $error("pins not functional after reset");
  a_boot_decode: assert property (s_settled |-> boot_download == (cap_r[2:1] == 2'b00)
    && boot_undefined == (cap_r[2:1] == 2'b10)) else $error("boot source wrong");
  a_log_decode: assert property (s_settled |-> console_log_en == cap_r[3])
    else $error("console log enable wrong");
  a_strap_read: assert property ((s_settled and s_rd_setup and paddr == 12'h000) ##1 psel && penable
    |-> prdata == {27'h0, cap_r}) else $error("strap readback wrong");
  a_slverr_map: assert property (psel && penable |-> pslverr == !map_w) else $error("error flag wrong");
  a_unmapped_zero: assert property ((s_rd_setup and !map_w) ##1 psel && penable |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_ready_high: assert property (psel && penable |-> pready) else $error("no ready in access");
endmodule : slbc_checker
bind slbc_top slbc_checker u_chk (.*);

/* tb/slbc_top_test.sv */
// Bench for the strap block: every strap pattern, undriven pads, overrides, bad address.
// Assumes the pad model resolves the strap pins; APB is driven here.
`timescale 1ns/10ps
module slbc_top_test;
  logic pclk = 1'b0, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, e, strap_func_en, flash_vdd_1v8, boot_download, boot_undefined;
  logic console_log_en, sdio_in_rising, sdio_out_rising;
  logic [4:0] pad, pu, pd, drv_en, drv_val, s;
  int error_cnt = 0, n_compared = 0;
  // Clock, 40 ns period
  initial forever #20 pclk = ~pclk;
  slbc_pad_model pm (.pclk(pclk), .drv_en(drv_en), .drv_val(drv_val), .pull_up_en(pu), .pull_dn_en(pd), .pad(pad));
  slbc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_select_strap(pad[0]), .boot_select_strap(pad[1]), .download_qualify_strap(pad[2]),
    .log_timing_strap(pad[3]), .sdio_edge_strap(pad[4]), .strap_pull_up_en(pu), .strap_pull_dn_en(pd),
    .strap_func_en(strap_func_en), .flash_vdd_1v8(flash_vdd_1v8), .boot_download(boot_download),
    .boot_undefined(boot_undefined), .console_log_en(console_log_en), .sdio_in_rising(sdio_in_rising),
    .sdio_out_rising(sdio_out_rising));
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // Watchdog, far beyond the expected run
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, drv_en, drv_val} <= '0;
    // Patterns 0..31 driven, 32 leaves every pad to the pulls
    for (int i = 0; i <= 32; i++) begin
      @(posedge pclk);
      presetn <= 1'b0;
      drv_en <= (i < 32) ? 5'h1f : 5'h00;
      drv_val <= i[4:0];
      s = (i < 32) ? i[4:0] : 5'h1a;
      repeat (2) @(posedge pclk);
      chk("pulls", {5'h1a, 5'h05, 1'b0}, {pu, pd, strap_func_en});
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      drv_en <= 5'h1f;
      drv_val <= ~s;
      apb(1'b0, 12'h000, 32'h0);
      chk("strap reg", {27'h0, s}, q);
      apb(1'b0, 12'h008, 32'h0);
      chk("status reg", {28'h0, s[4], s[3], s[3], s[0]}, q);
      chk("settings", {s[0], s[2:1] == 2'b00, s[2:1] == 2'b10, s[3], s[3], s[4]}, {flash_vdd_1v8,
        boot_download, boot_undefined, console_log_en, sdio_in_rising, sdio_out_rising});
    end
    $display("strap patterns done");
    apb(1'b1, 12'h004, 32'h0b);
    apb(1'b0, 12'h004, 32'h0);
    chk("ctrl", 32'h0b, q);
    chk("vdd ovr", 3'b111, {flash_vdd_1v8, sdio_in_rising, sdio_out_rising});
    apb(1'b1, 12'h004, 32'h14);
    apb(1'b0, 12'h008, 32'h0);
    chk("timing ovr", 32'ha, q);
    apb(1'b1, 12'h000, 32'h1f);
    apb(1'b0, 12'h000, 32'h0);
    chk("ro strap", 32'h1a, q);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    $display("override and access done");
    give_verdict();
  end
endmodule : slbc_top_test
